// *** sim/axle_count_occupancy_evaluator_bench.sv ***
// self-checking bench for the axle count evaluator
`timescale 1ns/1ps
`default_nettype none
module axle_count_occupancy_evaluator_bench;
    localparam int N       = 8;
    localparam int FILT    = 8;
    localparam int HOLD    = FILT + 4;
    localparam int TIMEOUT = 3000;
    logic         ref_clk            = 1'b0;
    logic         rst                = 1'b1;
    logic [N-1:0] occFirst           = 8'h00;
    logic [N-1:0] occSecond          = 8'h00;
    logic [N-1:0] badPolarity        = 8'h00;
    logic [N-1:0] pointEnable        = 8'hFF;
    logic [N-1:0] entryFirstToSecond = 8'h0F;
    logic [N-1:0] fA, fB, sA, sB;
    logic         clearContact, failSafe, minusCount;
    logic [axle_count_pkg::COUNT_W-1:0] axleCount;
    int           num_errors = 0;
    int           cmp_count  = 0;
    int           cycleCount = 0;

    ////////////////////////////////////////////////////////////////////////
    sensor_front_end_model #(.N(N)) i_sensor_front_end_model (
        .occFirst(occFirst), .occSecond(occSecond),
        .badPolarity(badPolarity), .firstA(fA), .firstB(fB),
        .secondA(sA), .secondB(sB));
    axle_count_occupancy_evaluator #(.NPOINTS(N), .FILT_CYC(FILT),
        .FAULTS(axle_count_pkg::FAULT_LIMIT))
        i_axle_count_occupancy_evaluator (
        .ref_clk(ref_clk), .rst(rst), .sysFirstA(fA), .sysFirstB(fB),
        .sysSecondA(sA), .sysSecondB(sB), .pointEnable(pointEnable),
        .entryFirstToSecond(entryFirstToSecond),
        .clearContact(clearContact), .failSafe(failSafe),
        .minusCount(minusCount), .axleCount(axleCount));

    always #12.5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == TIMEOUT) begin
            num_errors++;
            finish_test();
        end
    end
    // inputs always move a fixed delay after the edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic do_reset;
        rst = 1'b1;
        occFirst = 8'h00;
        occSecond = 8'h00;
        badPolarity = 8'h00;
        step(6);
        rst = 1'b0;
        step(2);
        check("axleCount", axleCount, 16'h0000);
        check("clearContact", clearContact, 16'h0001);
    endtask
    // four phases: lead on, both on, lead off, trailing off
    task automatic pass(input int pt, input logic firstLeads);
        if (firstLeads) occFirst[pt] = 1'b1;
        else occSecond[pt] = 1'b1;
        step(HOLD);
        occFirst[pt] = 1'b1;
        occSecond[pt] = 1'b1;
        step(HOLD);
        if (firstLeads) occFirst[pt] = 1'b0;
        else occSecond[pt] = 1'b0;
        step(HOLD);
        occFirst[pt] = 1'b0;
        occSecond[pt] = 1'b0;
        step(HOLD);
    endtask
    // one system only, never overlapping the other
    task automatic pulse(input int pt, input int len);
        occFirst[pt] = 1'b1;
        step(len);
        occFirst[pt] = 1'b0;
        step(HOLD);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_counting;
        pass(0, 1'b1);
        check("axleCount", axleCount, 16'h0001);
        check("clearContact", clearContact, 16'h0000);
        pass(7, 1'b0);
        check("axleCount", axleCount, 16'h0002);
        pass(3, 1'b0);
        check("axleCount", axleCount, 16'h0001);
        check("clearContact", clearContact, 16'h0000);
        pass(0, 1'b0);
        check("axleCount", axleCount, 16'h0000);
        check("clearContact", clearContact, 16'h0001);
        check("minusCount", minusCount, 16'h0000);
        pointEnable[5] = 1'b0;
        pass(5, 1'b0);
        check("axleCount", axleCount, 16'h0000);
        pointEnable[5] = 1'b1;
    endtask
    task automatic test_transient;
        repeat (4) pulse(1, FILT - 1);
        check("failSafe", failSafe, 16'h0000);
        check("axleCount", axleCount, 16'h0000);
        check("clearContact", clearContact, 16'h0001);
    endtask
    task automatic test_minus;
        pass(2, 1'b0);
        check("minusCount", minusCount, 16'h0001);
        check("axleCount", axleCount, 16'h0000);
        step(HOLD);
        check("clearContact", clearContact, 16'h0000);
        do_reset();
    endtask
    task automatic test_disassociated;
        repeat (axle_count_pkg::FAULT_LIMIT - 2) pulse(4, HOLD);
        // overlap, but the trailer drops out before the leader
        occFirst[4] = 1'b1;
        step(HOLD);
        occSecond[4] = 1'b1;
        step(HOLD);
        occSecond[4] = 1'b0;
        step(HOLD);
        occFirst[4] = 1'b0;
        step(HOLD);
        check("failSafe", failSafe, 16'h0000);
        check("axleCount", axleCount, 16'h0000);
        pulse(4, HOLD);
        check("failSafe", failSafe, 16'h0001);
        check("clearContact", clearContact, 16'h0000);
        do_reset();
    endtask
    task automatic test_polarity;
        badPolarity[6] = 1'b1;
        step(HOLD);
        check("failSafe", failSafe, 16'h0001);
        check("clearContact", clearContact, 16'h0000);
        pass(6, 1'b0);
        check("axleCount", axleCount, 16'h0000);
        check("minusCount", minusCount, 16'h0000);
        do_reset();
    endtask

    initial begin
        do_reset();
        test_counting();
        test_transient();
        test_minus();
        test_disassociated();
        test_polarity();
        finish_test();
    end
endmodule // axle_count_occupancy_evaluator_bench
`default_nettype wire

// *** sim/sensor_front_end_model.sv ***
// sensor front end model: redundant occupancy lines per sensing system
`timescale 1ns/1ps
`default_nettype none
module sensor_front_end_model #(
    parameter int N = 8
) (
    input  wire logic [N-1:0] occFirst,
    input  wire logic [N-1:0] occSecond,
    input  wire logic [N-1:0] badPolarity,
    output logic      [N-1:0] firstA,
    output logic      [N-1:0] firstB,
    output logic      [N-1:0] secondA,
    output logic      [N-1:0] secondB
);
    ////////////////////////////////////////////////////////////////////////
    // true line carries occupancy, the other line its complement
    assign firstA  = occFirst;
    assign secondA = occSecond;
    // a swapped pair makes both lines equal, which must be refused
    assign firstB  = badPolarity ^ ~occFirst;
    assign secondB = badPolarity ^ ~occSecond;
endmodule // sensor_front_end_model
`default_nettype wire

// *** verilog/axle_count_occupancy_evaluator.sv ***
// axle counting section evaluator: direction decode, count, clear contact
//
// Overview of operation
// - each valid pass into the section adds one to the section count.
// - each valid pass out of the section subtracts one from the count.
// - clear contact stays open while the count is one or more.
// - clear contact closes when the count returns to zero with no minus count and no fail-safe.
// - one counting point may count out of one section and into the next.
// - up to eight counting points feed the same section counter.
// - direction comes from which sensing system reports occupancy first.
// - per point, a configured order counts as entry, the opposite as exit.
// - logical first/second systems are fixed; physical reversal swaps inputs.
// - an axle counts only when both system pulses overlap in time.
// - pass phases: lead occupied, both, lead released, trailing released.
// - wrong-polarity sensor pairs force fail-safe occupied, no counting.
// - third non-overlapping or single-system pulse at one point forces fail-safe.
// - pulses shorter than four milliseconds are suppressed as transients.
`timescale 1ns/1ps
`default_nettype none
module axle_count_occupancy_evaluator #(
    parameter int NPOINTS   = axle_count_pkg::MAX_POINTS,
    parameter int FILT_CYC  = axle_count_pkg::TRANSIENT_CYC,
    parameter int FAULTS    = axle_count_pkg::FAULT_LIMIT
) (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // redundant outputs per system: A true, B complement
    input  wire logic [NPOINTS-1:0] sysFirstA,
    input  wire logic [NPOINTS-1:0] sysFirstB,
    input  wire logic [NPOINTS-1:0] sysSecondA,
    input  wire logic [NPOINTS-1:0] sysSecondB,
    input  wire logic [NPOINTS-1:0] pointEnable,
    input  wire logic [NPOINTS-1:0] entryFirstToSecond,
    output logic                    clearContact,
    output logic                    failSafe,
    output logic                    minusCount,
    output logic [axle_count_pkg::COUNT_W-1:0] axleCount
);
    localparam int FW = $clog2(FILT_CYC + 1);
    localparam logic [FW-1:0] FILT_MAX = FW'(FILT_CYC);

    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    logic [NPOINTS-1:0] incPulse;
    logic [NPOINTS-1:0] decPulse;
    logic [NPOINTS-1:0] pointFault;
    logic [NPOINTS-1:0] polarityBad;

    genvar g;
    generate
        for (g = 0; g < NPOINTS; g++) begin : gPoint
            logic [FW-1:0] cntA_reg;
            logic [FW-1:0] cntB_reg;
            axle_count_pkg::point_occ_t occ_reg;
            axle_count_pkg::pass_state_t st_reg;
            logic aFirst_reg;
            logic [1:0] faultCnt_reg;
            logic rawA;
            logic rawB;
            logic polBad;

            // both redundant lines agreeing means wrong polarity
            assign polBad = pointEnable[g] &&
                ((sysFirstA[g] == sysFirstB[g]) ||
                 (sysSecondA[g] == sysSecondB[g]));
            assign polarityBad[g] = polBad;
            assign rawA = sysFirstA[g];   // logical first, fixed
            assign rawB = sysSecondA[g];

            // a level change is accepted only after it holds 4 ms
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    cntA_reg  <= '0;
                    occ_reg.a <= 1'b0;
                end else if (rawA == occ_reg.a) begin
                    cntA_reg <= '0;
                end else if (cntA_reg >= FILT_MAX - 1'b1) begin
                    cntA_reg  <= '0;
                    occ_reg.a <= rawA;
                end else begin
                    cntA_reg <= cntA_reg + 1'b1;
                end
            end
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    cntB_reg  <= '0;
                    occ_reg.b <= 1'b0;
                end else if (rawB == occ_reg.b) begin
                    cntB_reg <= '0;
                end else if (cntB_reg >= FILT_MAX - 1'b1) begin
                    cntB_reg  <= '0;
                    occ_reg.b <= rawB;
                end else begin
                    cntB_reg <= cntB_reg + 1'b1;
                end
            end

            // four-phase pass tracker
            logic passDone;
            logic passBad;
            assign passDone = (st_reg == axle_count_pkg::PT_TRAIL) &&
                              !occ_reg.a && !occ_reg.b;
            // any clear-out not via the full sequence is disassociated
            assign passBad = (st_reg == axle_count_pkg::PT_BAD) &&
                             !occ_reg.a && !occ_reg.b;
            always_ff @(posedge ref_clk) begin
                if (rst || !pointEnable[g]) begin
                    st_reg     <= axle_count_pkg::PT_IDLE;
                    aFirst_reg <= 1'b0;
                end else begin
                    unique case (st_reg)
                        axle_count_pkg::PT_IDLE: begin
                            if (occ_reg.a && occ_reg.b)
                                st_reg <= axle_count_pkg::PT_BAD;
                            else if (occ_reg.a || occ_reg.b) begin
                                st_reg     <= axle_count_pkg::PT_LEAD;
                                aFirst_reg <= occ_reg.a;
                            end
                        end
                        axle_count_pkg::PT_LEAD: begin
                            if (occ_reg.a && occ_reg.b)
                                st_reg <= axle_count_pkg::PT_BOTH;
                            else if (!occ_reg.a && !occ_reg.b)
                                st_reg <= axle_count_pkg::PT_BAD;
                            else if (occ_reg.a != aFirst_reg)
                                st_reg <= axle_count_pkg::PT_BAD;
                        end
                        axle_count_pkg::PT_BOTH: begin
                            // leader must release first
                            if (aFirst_reg ? (!occ_reg.a && occ_reg.b)
                                           : (occ_reg.a && !occ_reg.b))
                                st_reg <= axle_count_pkg::PT_TRAIL;
                            else if (!(occ_reg.a && occ_reg.b))
                                st_reg <= axle_count_pkg::PT_BAD;
                        end
                        axle_count_pkg::PT_TRAIL: begin
                            if (!occ_reg.a && !occ_reg.b)
                                st_reg <= axle_count_pkg::PT_IDLE;
                            // leader back on before the trailer cleared
                            else if (aFirst_reg ? occ_reg.a : occ_reg.b)
                                st_reg <= axle_count_pkg::PT_BAD;
                        end
                        axle_count_pkg::PT_BAD: begin
                            if (!occ_reg.a && !occ_reg.b)
                                st_reg <= axle_count_pkg::PT_IDLE;
                        end
                        default: st_reg <= axle_count_pkg::PT_BAD;
                    endcase
                end
            end

            // configured order is entry, the opposite is exit
            assign incPulse[g] = passDone && !polBad &&
                                 (aFirst_reg == entryFirstToSecond[g]);
            assign decPulse[g] = passDone && !polBad &&
                                 (aFirst_reg != entryFirstToSecond[g]);

            // disassociated pulses accumulate; third trips
            always_ff @(posedge ref_clk) begin
                if (rst)
                    faultCnt_reg <= 2'h0;
                else if (passBad && faultCnt_reg != 2'(FAULTS))
                    faultCnt_reg <= faultCnt_reg + 2'h1;
            end
            assign pointFault[g] = (faultCnt_reg == 2'(FAULTS));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // section counter summing all points
    function automatic logic [3:0] popCount(input logic [NPOINTS-1:0] v);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < NPOINTS; i++)
            s = s + {3'h0, v[i]};
        return s;
    endfunction

    logic [axle_count_pkg::COUNT_W-1:0] count_reg;
    logic [axle_count_pkg::COUNT_W:0]   count_next;
    logic [3:0] nInc;
    logic [3:0] nDec;
    logic       minus_reg;
    logic       fail_reg;

    assign nInc = popCount(incPulse);
    assign nDec = popCount(decPulse);
    assign count_next = {1'b0, count_reg} +
                        {{(axle_count_pkg::COUNT_W-3){1'b0}}, nInc} -
                        {{(axle_count_pkg::COUNT_W-3){1'b0}}, nDec};

    always_ff @(posedge ref_clk) begin
        if (rst)
            count_reg <= axle_count_pkg::COUNT_RESET;
        else if (count_next[axle_count_pkg::COUNT_W])
            count_reg <= axle_count_pkg::COUNT_RESET;  // held at zero
        else
            count_reg <= count_next[axle_count_pkg::COUNT_W-1:0];
    end

    // minus count is sticky until reset
    always_ff @(posedge ref_clk) begin
        if (rst)
            minus_reg <= 1'b0;
        else if (count_next[axle_count_pkg::COUNT_W])
            minus_reg <= 1'b1;
    end

    // fail-safe latches on polarity or fault limit
    always_ff @(posedge ref_clk) begin
        if (rst)
            fail_reg <= 1'b0;
        else if (|polarityBad || |pointFault)
            fail_reg <= 1'b1;
    end

    // contact closed only when empty and healthy
    always_ff @(posedge ref_clk) begin
        if (rst)
            clearContact <= 1'b0;
        else
            clearContact <= (count_next == '0) && !minus_reg &&
                            !count_next[axle_count_pkg::COUNT_W] &&
                            !fail_reg && !(|polarityBad) && !(|pointFault);
    end

    assign axleCount  = count_reg;
    assign minusCount = minus_reg;
    assign failSafe   = fail_reg;

    ////////////////////////////////////////////////////////////////////////
    contact_open_a: assert property (
        (count_reg != '0) |-> !clearContact)
        else $error("contact closed with axles present");
    // the contact register only follows its terms after a cycle out of reset
    contact_close_a: assert property (
        $past(!rst && count_next == '0 && !minus_reg && !fail_reg &&
              !(|polarityBad) && !(|pointFault)) |-> clearContact)
        else $error("contact open with empty healthy section");
    count_up_a: assert property (
        (nInc == 4'h1 && nDec == 4'h0)
        |=> count_reg == $past(count_reg) + 1'b1)
        else $error("entry did not add one");
    count_down_a: assert property (
        (nDec == 4'h1 && nInc == 4'h0 && count_reg != '0)
        |=> count_reg == $past(count_reg) - 1'b1)
        else $error("exit did not subtract one");
    minus_flag_a: assert property (
        minus_reg |=> minus_reg && !clearContact)
        else $error("minus count lost");
    polarity_fail_a: assert property (
        (|polarityBad) |=> failSafe && !clearContact)
        else $error("polarity fault not fail-safe");
    fault_trip_a: assert property (
        (|pointFault) |=> failSafe)
        else $error("fault limit did not trip");
    fail_hold_a: assert property (
        failSafe |=> failSafe && !clearContact)
        else $error("fail-safe released without reset");
    no_polcount_a: assert property (
        (|polarityBad) |-> (((incPulse | decPulse) & polarityBad) == '0))
        else $error("counted on bad polarity");

    enter_c: cover property (@(posedge ref_clk) disable iff (rst)
        nInc != 4'h0);
    exit_c: cover property (@(posedge ref_clk) disable iff (rst)
        nDec != 4'h0 && count_reg != '0);
    minus_c: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(minus_reg));
    fail_c: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(fail_reg));
endmodule // axle_count_occupancy_evaluator
`default_nettype wire

// *** verilog/axle_count_pkg.sv ***
// shared constants and types for the axle count evaluator
package axle_count_pkg;
    localparam int CLK_HZ          = 40000000;
    localparam int TRANSIENT_US    = 4000;
    // least time in whole cycles; the MHz division truncates, no rounding up
    localparam int TRANSIENT_CYC   =
        (TRANSIENT_US * (CLK_HZ / 1000000) + 0) ;
    localparam int FAULT_LIMIT     = 3;
    localparam int MAX_POINTS      = 8;
    localparam int COUNT_W         = 12;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 12'h000;

    // per-point pass tracker, Gray along the usual path
    typedef enum logic [2:0] {
        PT_IDLE  = 3'b000,
        PT_LEAD  = 3'b001,
        PT_BOTH  = 3'b011,
        PT_TRAIL = 3'b010,
        PT_BAD   = 3'b110
    } pass_state_t;

    // filtered occupancy of one point: a = logical first, b = second
    typedef struct packed {
        logic a;
        logic b;
    } point_occ_t;
endpackage
